// ===== include/pcg_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
`define PCG_OFF_CSR 6'h00
`define PCG_OFF_MULT 6'h10
`define PCG_OFF_PRE 6'h14
`define PCG_OFF_CORE 6'h18
`define PCG_OFF_PERIPH 6'h1c
`define PCG_OFF_MEMIF 6'h20
`define PCG_OFF_OSC 6'h24
`define PCG_OFF_DEVICE_CONFIG_REG 6'h28
`define PCG_OFF_MEMIF_GLOBAL_CTRL 6'h2c
`define PCG_CSR_SEL_BIT 0
`define PCG_CSR_RST_BIT 3
`define PCG_CSR_LOCK_BIT 6
`define PCG_DIV_EN_BIT 15
`define PCG_DEVICE_CONFIG_REG_SRC_BIT 4
`define PCG_GBL_CK2_BIT 3
`define PCG_GBL_MEMIF_BIT 5
`define PCG_MULT_RST 5'h07
`define PCG_MULT_MIN 5'h04
`define PCG_MULT_MAX 5'h19
`define PCG_PRE_RST 5'h00
`define PCG_CORE_RST 5'h00
`define PCG_PERIPH_RST 5'h01
`define PCG_MEMIF_RST 5'h01
`define PCG_OSC_RST 5'h07
`define PCG_CLK_NS 40
`define PCG_RESET_TIME_NS 125
`define PCG_RESET_CYC ((`PCG_RESET_TIME_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS)
`define PCG_LOCK_TIME_US 187.5
`define PCG_NCO_SCALE 32
`endif

// ===== include/pcg_pkg.sv
// types shared by the clock generator modules
package pcg_pkg;
  typedef struct packed {
    logic enable;
    logic [4:0] ratio;
  } pcg_div_s;
  typedef enum logic [1:0] {
    PCG_IN_RESET,
    PCG_LOCKING,
    PCG_LOCKED
  } pcg_pll_e;
endpackage

// ===== src/pcg_div.sv
// programmable tick divider with clean ratio and enable changes
`include "pcg_map.svh"
module pcg_div
  import pcg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire pcg_div_s i_cfg,
  output logic o_clk,
  output logic o_tick
);
  logic [4:0] cnt;
  logic [4:0] ratio_q;
  logic en_q;
  logic wrap;

  assign wrap = i_tick && (cnt == ratio_q);

  // new settings only land at a period edge, so no shortened pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 5'h00;
      ratio_q <= 5'h00;
      en_q <= 1'b0;
    end else if (wrap) begin
      cnt <= 5'h00;
      ratio_q <= i_cfg.ratio; // see R21
      en_q <= i_cfg.enable; // see R21
    end else if (i_tick) begin
      cnt <= cnt + 5'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_clk <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= wrap && en_q; // see R5
      if (wrap) begin
        o_clk <= en_q ? ~o_clk : 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  ratio_at_wrap_a: assert property ($changed(ratio_q) |-> $past(wrap)) // see R21
    else $error("divider ratio changed mid period");
  tick_from_src_a: assert property (o_tick |-> $past(i_tick)) // see R5
    else $error("divided tick without source tick");
  clk_on_wrap_a: assert property ($changed(o_clk) |-> $past(wrap)) // see R21
    else $error("divided clock edge away from period boundary");
endmodule // pcg_div

// ===== src/pcg_pll.sv
// behavioural pll: prescaler, multiplier and lock timer
`include "pcg_map.svh"
module pcg_pll
  import pcg_pkg::*;
#(
  parameter int LOCK_CYC = 4687
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_pll_rst,
  input wire logic [4:0] i_pre,
  input wire logic [4:0] i_mult,
  output logic o_tick,
  output logic o_locked
);
  localparam logic [2:0] RST_CYC = 3'(`PCG_RESET_CYC);
  pcg_pll_e state;
  logic [2:0] rst_cnt;
  logic [12:0] lock_cnt;
  logic [10:0] acc;
  logic [10:0] limit;
  logic [4:0] mult_eff;
  logic [10:0] next_acc;

  // out of range factors clamp to the supported span
  always_comb begin
    if (i_mult < `PCG_MULT_MIN) mult_eff = `PCG_MULT_MIN; // see R2
    else if (i_mult > `PCG_MULT_MAX) mult_eff = `PCG_MULT_MAX; // see R2
    else mult_eff = i_mult;
  end

  // output rate = mult / (prescale * scale) of the input clock
  assign limit = 11'(({6'h00, i_pre} + 11'h001) * `PCG_NCO_SCALE); // see R1
  assign next_acc = acc + {6'h00, mult_eff}; // see R2

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc <= 11'h000;
      o_tick <= 1'b0;
    end else if (state != PCG_LOCKED) begin
      acc <= 11'h000;
      o_tick <= 1'b0;
    end else if (next_acc >= limit) begin
      acc <= next_acc - limit;
      o_tick <= 1'b1;
    end else begin
      acc <= next_acc;
      o_tick <= 1'b0;
    end
  end

  // a reset shorter than the minimum is not counted as a real reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= PCG_IN_RESET;
      rst_cnt <= 3'h0;
      lock_cnt <= 13'h0000;
    end else if (i_pll_rst) begin
      lock_cnt <= 13'h0000;
      if (rst_cnt < RST_CYC) rst_cnt <= rst_cnt + 3'h1;
      else state <= PCG_IN_RESET;
    end else begin
      rst_cnt <= 3'h0;
      unique case (state)
        PCG_IN_RESET: state <= PCG_LOCKING;
        PCG_LOCKING: begin
          if (lock_cnt >= 13'(LOCK_CYC - 1)) state <= PCG_LOCKED;
          else lock_cnt <= lock_cnt + 13'h0001;
        end
        PCG_LOCKED: state <= PCG_LOCKED;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) o_locked <= 1'b0;
    else o_locked <= (state == PCG_LOCKED);
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  mult_range_a: assert property (mult_eff inside {[4:25]}) // see R2
    else $error("multiplier outside 4 to 25");
  no_tick_rst_a: assert property (!o_locked |=> !o_tick) // see R19
    else $error("pll ticks while not locked");
endmodule // pcg_pll

// ===== src/pcg_top.sv
// pll clock generator: registers, path select and clock dividers
//
// Operation
// R1: prescaler divides the input reference by 1 to 32 before the pll.
// R2: pll multiplies the prescaled reference by 4 to 25.
// R3: oscillator divider divides the raw input by 1 to 32 to aux pin.
// R4: path select 0 uses input clock, 1 uses pll output.
// R5: core, bus and memory clocks each have own divider off reference.
// R6: software sets the bus clock to exactly half the core clock.
// R7: when slowing, software writes bus divider before core divider.
// R8: when speeding up, software writes core divider before bus divider.
// R9: software never clears core or bus divider enables.
// R10: software holds pll reset at least 125 ns.
// R11: software waits the lock time before selecting the pll path.
// R12: software bypasses before changing prescaler, mode, input or factor.
// R13: second clock output is bus clock, gated by two enable bits.
// R14: third clock output derives from input, gated by oscillator enable.
// R15: memory clock output picks divider or external input, gated by bit 5.
// R16: memory clock divides pll output or comes from external input.
// R17: software keeps reference, pll output and memory clock in range.
// R18: only cpu or emulation changes these registers, not the host port.
// R19: pll reset bit holds the pll in reset when set, set after reset.
// R20: bypass is default and feeds the dividers with the input directly.
// R21: path switches and ratio changes make no runt clock pulses.
`include "pcg_map.svh"
module pcg_top
  import pcg_pkg::*;
#(
  parameter int LOCK_CYC = $rtoi(`PCG_LOCK_TIME_US * 1000.0 / `PCG_CLK_NS)
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_MEMIF_CLK_IN,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  output logic O_CORE_CLK,
  output logic O_PERIPH_CLK,
  output logic O_MEMIF_CLK,
  output logic O_SECOND_CLOCK_OUTPUT,
  output logic O_THIRD_CLOCK_OUTPUT,
  output logic O_MEMIF_CLKOUT,
  output logic O_PLL_RESET,
  output logic O_PLL_LOCKED
);
  logic path_sel_req;
  logic path_sel;
  logic pll_reset_ctl;
  logic [4:0] mult;
  logic [4:0] pre;
  pcg_div_s core_cfg;
  pcg_div_s periph_cfg;
  pcg_div_s memif_cfg;
  pcg_div_s osc_cfg;
  logic memif_src;
  logic ck2_gate;
  logic memif_gate;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [5:0] off;
  logic [31:0] next_rdata;
  logic pll_tick;
  logic pll_locked;
  logic hf_tick;
  logic core_tick;
  logic core_clk;
  logic periph_clk;
  logic memif_clk;
  logic osc_clk;
  logic memif_in_q;

  assign off = I_PADDR[5:0];
  assign wr_en = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && mapped;
  assign rd_setup = I_PSEL && !I_PENABLE;

  always_comb begin
    unique case (off)
      `PCG_OFF_CSR, `PCG_OFF_MULT, `PCG_OFF_PRE, `PCG_OFF_CORE,
      `PCG_OFF_PERIPH, `PCG_OFF_MEMIF, `PCG_OFF_OSC, `PCG_OFF_DEVICE_CONFIG_REG,
      `PCG_OFF_MEMIF_GLOBAL_CTRL: mapped = (I_PADDR[31:6] == 26'h0000000);
      default: mapped = 1'b0;
    endcase
  end

  // apb: one wait-free access cycle, ready and data come from flops
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end else begin
      O_PREADY <= rd_setup;
      O_PSLVERR <= rd_setup && !mapped;
      O_PRDATA <= (rd_setup && !I_PWRITE && mapped) ? next_rdata :
                  32'h00000000;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (off)
      `PCG_OFF_CSR: begin
        next_rdata[`PCG_CSR_SEL_BIT] = path_sel_req;
        next_rdata[`PCG_CSR_RST_BIT] = pll_reset_ctl;
        next_rdata[`PCG_CSR_LOCK_BIT] = pll_locked;
      end
      `PCG_OFF_MULT: next_rdata[4:0] = mult;
      `PCG_OFF_PRE: next_rdata[4:0] = pre;
      `PCG_OFF_CORE: next_rdata = {16'h0000, core_cfg.enable, 10'h000,
                                   core_cfg.ratio};
      `PCG_OFF_PERIPH: next_rdata = {16'h0000, periph_cfg.enable, 10'h000,
                                     periph_cfg.ratio};
      `PCG_OFF_MEMIF: next_rdata = {16'h0000, memif_cfg.enable, 10'h000,
                                    memif_cfg.ratio};
      `PCG_OFF_OSC: next_rdata = {16'h0000, osc_cfg.enable, 10'h000,
                                  osc_cfg.ratio};
      `PCG_OFF_DEVICE_CONFIG_REG: next_rdata[`PCG_DEVICE_CONFIG_REG_SRC_BIT] = memif_src;
      `PCG_OFF_MEMIF_GLOBAL_CTRL: begin
        next_rdata[`PCG_GBL_CK2_BIT] = ck2_gate;
        next_rdata[`PCG_GBL_MEMIF_BIT] = memif_gate;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // control register: bypass and pll reset are the reset defaults
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      path_sel_req <= 1'b0; // see R20
      pll_reset_ctl <= 1'b1; // see R19
    end else if (wr_en && off == `PCG_OFF_CSR) begin
      path_sel_req <= I_PWDATA[`PCG_CSR_SEL_BIT];
      pll_reset_ctl <= I_PWDATA[`PCG_CSR_RST_BIT]; // see R19
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mult <= `PCG_MULT_RST;
      pre <= `PCG_PRE_RST;
    end else if (wr_en && off == `PCG_OFF_MULT) begin
      mult <= I_PWDATA[4:0]; // see R2
    end else if (wr_en && off == `PCG_OFF_PRE) begin
      pre <= I_PWDATA[4:0]; // see R1
    end
  end

  // divider enables stay writable; clearing core or bus is a misuse
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      core_cfg <= '{enable: 1'b1, ratio: `PCG_CORE_RST};
      periph_cfg <= '{enable: 1'b1, ratio: `PCG_PERIPH_RST};
      memif_cfg <= '{enable: 1'b1, ratio: `PCG_MEMIF_RST};
      osc_cfg <= '{enable: 1'b1, ratio: `PCG_OSC_RST};
    end else if (wr_en) begin
      if (off == `PCG_OFF_CORE)
        core_cfg <= {I_PWDATA[`PCG_DIV_EN_BIT], I_PWDATA[4:0]};
      if (off == `PCG_OFF_PERIPH)
        periph_cfg <= {I_PWDATA[`PCG_DIV_EN_BIT], I_PWDATA[4:0]};
      if (off == `PCG_OFF_MEMIF)
        memif_cfg <= {I_PWDATA[`PCG_DIV_EN_BIT], I_PWDATA[4:0]};
      if (off == `PCG_OFF_OSC)
        osc_cfg <= {I_PWDATA[`PCG_DIV_EN_BIT], I_PWDATA[4:0]}; // see R3
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      memif_src <= 1'b0; // see R15
      ck2_gate <= 1'b1; // see R13
      memif_gate <= 1'b1; // see R15
    end else if (wr_en && off == `PCG_OFF_DEVICE_CONFIG_REG) begin
      memif_src <= I_PWDATA[`PCG_DEVICE_CONFIG_REG_SRC_BIT];
    end else if (wr_en && off == `PCG_OFF_MEMIF_GLOBAL_CTRL) begin
      ck2_gate <= I_PWDATA[`PCG_GBL_CK2_BIT];
      memif_gate <= I_PWDATA[`PCG_GBL_MEMIF_BIT];
    end
  end

  pcg_pll #(
    .LOCK_CYC(LOCK_CYC)
  ) u_pll (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_pll_rst(pll_reset_ctl),
    .i_pre(pre),
    .i_mult(mult),
    .o_tick(pll_tick),
    .o_locked(pll_locked)
  );

  // path change waits for a core period boundary (at once while the core divider is disabled) to avoid a runt edge
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) path_sel <= 1'b0; // see R20
    else if (core_tick || !core_cfg.enable) path_sel <= path_sel_req; // see R21
  end

  assign hf_tick = path_sel ? pll_tick : 1'b1; // see R4

  pcg_div u_core (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_tick(hf_tick),
    .i_cfg(core_cfg),
    .o_clk(core_clk),
    .o_tick(core_tick)
  );

  pcg_div u_periph (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_tick(hf_tick),
    .i_cfg(periph_cfg),
    .o_clk(periph_clk),
    .o_tick()
  );

  pcg_div u_memif (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_tick(hf_tick),
    .i_cfg(memif_cfg),
    .o_clk(memif_clk),
    .o_tick()
  );

  // oscillator divider runs off the raw input in every mode
  pcg_div u_osc (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_tick(1'b1),
    .i_cfg(osc_cfg),
    .o_clk(osc_clk),
    .o_tick()
  );

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) memif_in_q <= 1'b0;
    else memif_in_q <= I_MEMIF_CLK_IN;
  end

  // pin stage adds one flop so every output leaves a register
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CORE_CLK <= 1'b0;
      O_PERIPH_CLK <= 1'b0;
      O_MEMIF_CLK <= 1'b0;
      O_SECOND_CLOCK_OUTPUT <= 1'b0;
      O_THIRD_CLOCK_OUTPUT <= 1'b0;
      O_MEMIF_CLKOUT <= 1'b0;
      O_PLL_RESET <= 1'b1;
      O_PLL_LOCKED <= 1'b0;
    end else begin
      O_CORE_CLK <= core_clk; // see R5
      O_PERIPH_CLK <= periph_clk; // see R5
      O_MEMIF_CLK <= memif_src ? memif_in_q : memif_clk; // see R16
      O_SECOND_CLOCK_OUTPUT <= periph_clk && periph_cfg.enable && ck2_gate; // see R13
      O_THIRD_CLOCK_OUTPUT <= osc_clk && osc_cfg.enable; // see R14
      O_MEMIF_CLKOUT <= memif_gate &&
                        (memif_src ? memif_in_q : memif_clk); // see R15
      O_PLL_RESET <= pll_reset_ctl; // see R19
      O_PLL_LOCKED <= pll_locked;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  sequence csr_write_s;
    wr_en && off == `PCG_OFF_CSR;
  endsequence

  pll_reset_bit_a: assert property (csr_write_s ##0
    I_PWDATA[`PCG_CSR_RST_BIT] |-> ##2 O_PLL_RESET) // see R19
    else $error("pll reset not asserted after write");
  bypass_feed_a: assert property (!path_sel |-> hf_tick) // see R20
    else $error("bypass does not pass the input clock");
  pll_path_a: assert property (path_sel |-> hf_tick == pll_tick) // see R4
    else $error("pll path not selected");
  path_switch_a: assert property ($changed(path_sel) |->
    $past(core_tick || !core_cfg.enable)) // see R21
    else $error("path switched mid core period");
  second_clock_output_gate_a: assert property (!ck2_gate || !periph_cfg.enable
    |=> !O_SECOND_CLOCK_OUTPUT) // see R13
    else $error("second clock output not gated");
  third_clock_output_gate_a: assert property (!osc_cfg.enable |=> !O_THIRD_CLOCK_OUTPUT) // see R14
    else $error("third clock output not gated");
  memif_ext_a: assert property (memif_src && memif_gate
    |=> O_MEMIF_CLKOUT == $past(memif_in_q)) // see R15
    else $error("memory clock output ignores external input");
  memif_div_a: assert property (!memif_src
    |=> O_MEMIF_CLK == $past(memif_clk)) // see R16
    else $error("memory clock not from its divider");
  apb_ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("apb access phase not ready");
endmodule // pcg_top

// ===== dv/pcg_top_test.sv
// self-checking bench for the clock generator: apb tasks and clock periods
`include "pcg_map.svh"
module pcg_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic mem_in = 1'b0;
  logic [2:0] mem_cnt = 3'h0;
  logic pready, pslverr, core_clk, periph_clk, memif_clk;
  logic ck2, ck3, mem_ckout, pll_rst, pll_lock;
  logic [31:0] prdata;
  int mismatches = 0;
  int comparisons = 0;
  int per;

  pcg_top #(.LOCK_CYC(LOCK)) dut (
    .I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_MEMIF_CLK_IN(mem_in), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PRDATA(prdata), .O_CORE_CLK(core_clk), .O_PERIPH_CLK(periph_clk),
    .O_MEMIF_CLK(memif_clk), .O_SECOND_CLOCK_OUTPUT(ck2), .O_THIRD_CLOCK_OUTPUT(ck3),
    .O_MEMIF_CLKOUT(mem_ckout), .O_PLL_RESET(pll_rst),
    .O_PLL_LOCKED(pll_lock)
  );

  always #20 clk = ~clk;

  // external memory clock: period of 10 cycles, unrelated to dividers
  always @(posedge clk) begin
    mem_cnt <= (mem_cnt == 3'h4) ? 3'h0 : mem_cnt + 3'h1;
    if (mem_cnt == 3'h4) begin
      mem_in <= ~mem_in;
    end
  end

  function automatic logic clks(input int idx);
    logic [5:0] v;
    v = {mem_ckout, ck3, ck2, memif_clk, periph_clk, core_clk};
    return v[idx];
  endfunction

  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_reg(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_per(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      $display("MISMATCH pready expected 1 seen %b", pready);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, a, d, rd, err);
    check_reg("write error", 32'h0, {31'h0, err});
  endtask

  task automatic rchk(input string name, input logic [31:0] a,
                      input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    xfer(1'b0, a, 32'h0, rd, err);
    check_reg(name, exp, rd);
    check_reg({name, " error"}, {31'h0, exp_err}, {31'h0, err});
  endtask

  // period in cycles between the second and third rising edge; 0 if none
  task automatic measure(input int idx, output int p_out);
    logic p;
    int n, r;
    p = 1'b1;
    r = 0;
    n = 0;
    p_out = 0;
    while (r < 3 && n < 1200) begin
      @(posedge clk);
      n++;
      p_out++;
      if (clks(idx) && !p) begin
        r++;
        if (r < 3) p_out = 0;
      end
      p = clks(idx);
    end
    if (r < 3) p_out = 0;
  endtask

  task automatic pchk(input string name, input int idx, input int exp);
    measure(idx, per);
    check_per(name, exp, per);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    check_reg("pll reset pin", 32'h1, {31'h0, pll_rst});
    rchk("csr", `PCG_OFF_CSR, 32'h8, 1'b0);
    rchk("mult", `PCG_OFF_MULT, 32'h7, 1'b0);
    rchk("core", `PCG_OFF_CORE, 32'h8000, 1'b0);
    rchk("periph", `PCG_OFF_PERIPH, 32'h8001, 1'b0);
    rchk("osc", `PCG_OFF_OSC, 32'h8007, 1'b0);
    rchk("gbl", `PCG_OFF_MEMIF_GLOBAL_CTRL, 32'h28, 1'b0);
    rchk("unmapped", 32'h40, 32'h0, 1'b1);
    rchk("gap", 32'h04, 32'h0, 1'b1);
    // defaults: bypass, bus clock half the core clock
    pchk("core bypass", 0, 2);
    pchk("periph", 1, 4);
    pchk("memif", 2, 4);
    pchk("second_clock_output", 3, 4);
    pchk("third_clock_output", 4, 16);
    pchk("memif out", 5, 4);
    // reserved bits ignored, ratio field boundaries
    wr(`PCG_OFF_CORE, 32'hffff_ffe2);
    rchk("core rsvd", `PCG_OFF_CORE, 32'h8002, 1'b0);
    pchk("core /3", 0, 6);
    wr(`PCG_OFF_CORE, 32'h801f);
    pchk("core /32", 0, 64);
    wr(`PCG_OFF_CORE, 32'h8001);
    wr(`PCG_OFF_PERIPH, 32'h8003);
    pchk("periph /4", 1, 8);
    pchk("core /2", 0, 4);
    wr(`PCG_OFF_OSC, 32'h801f);
    pchk("third_clock_output /32", 4, 64);
    wr(`PCG_OFF_OSC, 32'h0000);
    pchk("third_clock_output off", 4, 0);
    wr(`PCG_OFF_MEMIF_GLOBAL_CTRL, 32'h20);
    pchk("second_clock_output off", 3, 0);
    wr(`PCG_OFF_MEMIF_GLOBAL_CTRL, 32'h08);
    pchk("memif out off", 5, 0);
    wr(`PCG_OFF_MEMIF_GLOBAL_CTRL, 32'h28);
    wr(`PCG_OFF_DEVICE_CONFIG_REG, 32'h10);
    pchk("memif out ext", 5, 10);
    wr(`PCG_OFF_DEVICE_CONFIG_REG, 32'h00);
    wr(`PCG_OFF_OSC, 32'h8007);
    // pll: prescale /2, multiply x16, tick every 4 cycles
    wr(`PCG_OFF_PRE, 32'h1);
    wr(`PCG_OFF_MULT, 32'h10);
    wr(`PCG_OFF_CORE, 32'h8000);
    wr(`PCG_OFF_PERIPH, 32'h8001);
    wr(`PCG_OFF_CSR, 32'h0);
    check_reg("lock early", 32'h0, {31'h0, pll_lock});
    repeat (LOCK + 20) @(posedge clk);
    check_reg("pll reset off", 32'h0, {31'h0, pll_rst});
    rchk("csr locked", `PCG_OFF_CSR, 32'h40, 1'b0);
    wr(`PCG_OFF_CSR, 32'h41);
    pchk("core pll", 0, 8);
    pchk("periph pll", 1, 16);
    pchk("memif pll", 2, 16);
    pchk("third_clock_output raw", 4, 16);
    wr(`PCG_OFF_CSR, 32'h40);
    pchk("core back", 0, 2);
    wr(`PCG_OFF_PERIPH, 32'h8007);
    wr(`PCG_OFF_CORE, 32'h8003);
    pchk("core /4", 0, 8);
    pchk("periph /8", 1, 16);
    wr(`PCG_OFF_CSR, 32'h08);
    repeat (8) @(posedge clk);
    check_reg("pll reset on", 32'h1, {31'h0, pll_rst});
    check_reg("lock lost", 32'h0, {31'h0, pll_lock});
    rchk("csr reset", `PCG_OFF_CSR, 32'h8, 1'b0);
    conclude();
  end
endmodule // pcg_top_test
